// ---- pkg/afd_pkg.sv ----
// Purpose: Shared constants and types for the adaptive dither pipeline
// Assumes: pclk at 10 MHz, APB register access, 32-bit data
// Notes:   Cell bits are red, green, blue from msb to lsb
// Notes on behaviour
// - Each 8-bit colour becomes 6 bits
// - Two output lsbs stay zero while enabled
// - Two dither stages, each enabled separately
// - First stage feeds the white balance table
// - Second stage reduces the table's output
// - Widen each colour to 9 bits first
// - Pick one of four algorithms per pixel
// - Special handling for black, white, saturated subpixels
// - Cell bit set adds one, clear passes
// - Three 9-bit lsbs select the pattern
// - Pattern 001 spans 4x4x8, four per 32
// - Temporal and spatial dithering combined
// - Detected pixel patterns select spatial method
package afd_pkg;
    localparam logic [11:0] AFD_CTRL_OFS   = 12'h000;
    localparam logic [11:0] AFD_STAT_OFS   = 12'h004;
    localparam int          AFD_PRE_EN     = 0;
    localparam int          AFD_POST_EN    = 1;
    localparam int          AFD_WB_EN      = 2;
    localparam int          AFD_DE_ONLY    = 3;
    localparam int          AFD_FS_POL     = 4;
    localparam int          AFD_LS_POL     = 5;
    localparam int          AFD_AV_POL     = 6;
    localparam logic [6:0]  AFD_CTRL_RST   = 7'h00;
    localparam logic [1:0]  AFD_BUF_DEPTH  = 2'h2;
    localparam logic [2:0]  AFD_LSB_TABLED = 3'h1;
    localparam logic [1:0]  AFD_CELL_R     = 2'h2;
    localparam logic [1:0]  AFD_CELL_G     = 2'h1;
    localparam logic [1:0]  AFD_CELL_B     = 2'h0;

    typedef struct packed {
        logic       fs;
        logic       ls;
        logic       av;
        logic [7:0] r;
        logic [7:0] g;
        logic [7:0] b;
    } afd_pix_s;

    typedef struct packed {
        logic en;
        logic de_only;
        logic fs_pol;
        logic ls_pol;
        logic av_pol;
    } afd_cfg_s;

    typedef enum {ALG_DEFAULT, ALG_BLACK, ALG_WHITE, ALG_SUBPIX} afd_alg_e;

    typedef logic [7:0][2:0] afd_row_t;

    // Row index is {frame, line}; element index is pixel
    localparam afd_row_t AFD_PAT001 [16] = '{
        24'h08_0002, 24'h00_5005, 24'h00_2080, 24'h14_0140,
        24'h00_0000, 24'h03_8038, 24'h00_0000, 24'he0_0e00,
        24'h00_2080, 24'h14_0140, 24'h08_0002, 24'h00_5005,
        24'h00_0000, 24'he0_0e00, 24'h00_0000, 24'h03_8038
    };
endpackage

// ---- verification/afd_panel_model.sv ----
// Purpose: Panel side and white balance table stand-in
// Assumes: Table answer is combinational from the addressing pixel
// Notes:   stall 0 always ready, 1 every other cycle, 2 held off
`timescale 1ns/10ps
module afd_panel_model (
    input  wire logic              pclk,
    input  wire logic              presetn,
    input  wire logic [1:0]        stall,
    input  wire afd_pkg::afd_pix_s table_pix,
    output logic [23:0]            table_rdata,
    output logic                   out_ready
);
    // Colour rotation shows where the table sits in the path
    assign table_rdata = {table_pix.g, table_pix.b, table_pix.r};

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            out_ready <= 1'b0;
        end else begin
            out_ready <= (stall == 2'h0) || (stall == 2'h1 && !out_ready);
        end
    end
endmodule

// ---- verification/testbench.sv ----
// Purpose: Register, latency, pattern and stall tests of afd_top
// Assumes: One APB wait state, three-edge pixel latency
// Notes:   Pattern check counts hits per 32 pixels, so alignment is free
`timescale 1ns/10ps
module testbench;
    localparam logic [11:0] CT = afd_pkg::AFD_CTRL_OFS;
    localparam logic [11:0] ST = afd_pkg::AFD_STAT_OFS;
    localparam logic [6:0]  LC_CTRL [6] = '{7'h00, 7'h03, 7'h04,
                                           7'h05, 7'h06, 7'h01};
    localparam logic [23:0] LC_IN [6] = '{24'h12_3456, 24'h40_247C,
        24'h12_3456, 24'hFF_4024, 24'h40_24FF, 24'hFF_FFFF};
    localparam logic [23:0] LC_TAB [6] = '{24'h12_3456, 24'h40_247C,
        24'h12_3456, 24'hFC_4024, 24'h40_24FF, 24'hFC_FCFC};
    localparam logic [23:0] LC_OUT [6] = '{24'h12_3456, 24'h40_247C,
        24'h34_5612, 24'h40_24FC, 24'h24_FC40, 24'hFC_FCFC};
    localparam logic [31:0] FR_CTRL [3] = '{32'h0000_0071, 32'h0000_0072,
                                            32'h0000_0049};
    logic              pclk      = 1'b0;
    logic              presetn   = 1'b0;
    logic              psel      = 1'b0;
    logic              penable   = 1'b0;
    logic              pwrite    = 1'b0;
    logic [11:0]       paddr     = 12'h000;
    logic [31:0]       pwdata    = 32'h0000_0000;
    logic              in_valid  = 1'b0;
    afd_pkg::afd_pix_s in_pix    = '0;
    logic [1:0]        stall     = 2'h0;
    logic [31:0]       prdata;
    logic              pready;
    logic              pslverr;
    logic              in_ready;
    afd_pkg::afd_pix_s table_pix;
    logic [23:0]       table_rdata;
    logic              out_valid;
    afd_pkg::afd_pix_s out_pix;
    logic              out_ready;
    int                err_total = 0;
    int                n_compared = 0;
    logic [31:0]       rd;
    logic              er;
    afd_pkg::afd_pix_s got_q [$];

    afd_top u_dut (.pclk(pclk), .presetn(presetn), .psel(psel),
        .penable(penable), .pwrite(pwrite), .paddr(paddr),
        .pwdata(pwdata), .prdata(prdata), .pready(pready),
        .pslverr(pslverr), .in_valid(in_valid), .in_pix(in_pix),
        .in_ready(in_ready), .table_pix(table_pix),
        .table_rdata(table_rdata), .out_valid(out_valid),
        .out_pix(out_pix), .out_ready(out_ready));
    afd_panel_model u_panel (.pclk(pclk), .presetn(presetn),
        .stall(stall), .table_pix(table_pix),
        .table_rdata(table_rdata), .out_ready(out_ready));

    initial begin
        forever #50 pclk = ~pclk;
    end

    always @(posedge pclk) begin
        if (out_valid === 1'b1 && out_ready === 1'b1) begin
            got_q.push_back(out_pix);
        end
    end

    task automatic check(input logic [31:0] got, input logic [31:0] exp);
        n_compared++;
        if (got !== exp) begin
            err_total++;
            $display("unexpected at %0t: got %h expected %h",
                     $time, got, exp);
        end
    endtask

    task automatic apb(input logic w, input logic [11:0] a,
                       input logic [31:0] d);
        @(posedge pclk);
        psel    <= 1'b1;
        penable <= 1'b0;
        pwrite  <= w;
        paddr   <= a;
        pwdata  <= d;
        @(posedge pclk);
        penable <= 1'b1;
        do begin
            @(posedge pclk);
        end while (pready !== 1'b1);
        rd = prdata;
        er = pslverr;
        psel    <= 1'b0;
        penable <= 1'b0;
        pwdata  <= ~d;
    endtask

    // Holds valid between back-to-back pixels; caller releases it
    task automatic send(input afd_pkg::afd_pix_s p);
        in_valid <= 1'b1;
        in_pix   <= p;
        do begin
            @(posedge pclk);
        end while (in_ready !== 1'b1);
    endtask

    task automatic finish_test;
        $display("compared %0d mismatches %0d", n_compared, err_total);
        if (err_total == 0 && n_compared > 0) begin
            $display("Test passed");
        end else begin
            $display("Test failed");
        end
        $finish;
    endtask

    initial begin
        #1_000_000;
        err_total++;
        finish_test();
    end

    initial begin
        int                n;
        int                odd;
        int                hit [3];
        logic [23:0]       v;
        logic [31:0]       s0;
        afd_pkg::afd_pix_s exp_q [8];
        repeat (16) @(posedge pclk);
        presetn <= 1'b1;
        apb(1'b0, ST, 32'h0000_0000);
        check(rd, 32'h0000_0001);
        apb(1'b0, CT, 32'h0000_0000);
        check(rd, 32'h0000_0000);
        apb(1'b1, 12'h008, 32'hFFFF_FFFF);
        check(er, 1'b1);
        apb(1'b0, 12'h008, 32'h0000_0000);
        check(er, 1'b1);
        check(rd, 32'h0000_0000);
        apb(1'b1, CT, 32'hFFFF_FFFF);
        apb(1'b0, CT, 32'h0000_0000);
        check(rd, 32'h0000_007F);
        // Six enable settings: table input after two edges, output after three
        for (int k = 0; k < 6; k++) begin
            apb(1'b1, CT, {25'h0, LC_CTRL[k]});
            send({3'b101, LC_IN[k]});
            in_valid <= 1'b0;
            in_pix   <= ~in_pix;
            @(posedge pclk);
            #1;
            check(table_pix, {3'b101, LC_TAB[k]});
            check(out_valid, 1'b0);
            @(posedge pclk);
            #1;
            check(out_valid, 1'b1);
            check(out_pix, {3'b101, LC_OUT[k]});
        end
        // Level 0x80 frame: each stage alone, then active-video-only timing
        for (int k = 0; k < 3; k++) begin
            apb(1'b1, CT, FR_CTRL[k]);
            apb(1'b0, ST, 32'h0000_0000);
            s0 = rd;
            got_q.delete();
            // Long blank gap marks the frame start in that mode
            if (k == 2) begin
                repeat (20) send('0);
            end
            for (int l = 0; l < 4; l++) begin
                send({l ? 3'b010 : 3'b110, 24'h00_0000});
                for (int p = 0; p < 8; p++) begin
                    send({3'b001, 24'h80_8080});
                end
            end
            in_valid <= 1'b0;
            repeat (10) @(posedge pclk);
            n = 0;
            odd = 0;
            hit = '{0, 0, 0};
            foreach (got_q[i]) begin
                if (got_q[i].av === 1'b1) begin
                    n++;
                    v = got_q[i][23:0];
                    for (int c = 0; c < 3; c++) begin
                        if (v[c*8+:8] === 8'h84) hit[c]++;
                        else if (v[c*8+:8] !== 8'h80) odd++;
                    end
                end
            end
            check(n, 32);
            check(odd, 0);
            foreach (hit[c]) check(hit[c], 4);
            apb(1'b0, ST, 32'h0000_0000);
            n = (k == 1) ? 2 : 4;
            check(((rd >> n) - (s0 >> n)) & 3, 1);
        end
        // Panel stalls: buffer fills, refuses, then drains in order
        apb(1'b1, CT, 32'h0000_0000);
        got_q.delete();
        stall <= 2'h2;
        for (int i = 0; i < 8; i++) begin
            exp_q[i] = {3'b000, 8'(i), 8'(i * 3), 8'h5A};
        end
        fork
            begin
                foreach (exp_q[i]) send(exp_q[i]);
                in_valid <= 1'b0;
            end
            begin
                repeat (12) @(posedge pclk);
                apb(1'b0, ST, 32'h0000_0000);
                check(rd & 32'h0000_00C3, 32'h0000_0082);
                stall <= 2'h1;
            end
        join
        repeat (40) @(posedge pclk);
        check(got_q.size(), 8);
        foreach (exp_q[i]) check(got_q[i], exp_q[i]);
        finish_test();
    end
endmodule

// ---- verilog/afd_dither.sv ----
// Purpose: One adaptive dither stage, one cycle of latency
// Assumes: ce stalls the stage; timing travels with the pixel
// Notes:   Disabled stage still registers, so latency never changes
`timescale 1ns/10ps
module afd_dither (
    input  wire logic              pclk,
    input  wire logic              presetn,
    input  wire logic              ce,
    input  wire logic              vld_in,
    input  wire afd_pkg::afd_cfg_s cfg,
    input  wire afd_pkg::afd_pix_s pix_in,
    output logic                   vld_out,
    output afd_pkg::afd_pix_s      pix_out,
    output logic [1:0]             frame_idx
);
    logic              fs_a, ls_a, av_a;
    logic              fs_d, ls_d, av_d;
    logic              step, f_start, l_start;
    logic [1:0]        frame_cur, line_idx, line_cur;
    logic [2:0]        pix_idx, pix_cur;
    logic [15:0]       gap_cnt, run_cnt, run_len;
    logic              inc_r, inc_g, inc_b;
    afd_pkg::afd_alg_e alg;

    function automatic logic full(input logic [7:0] c);
        full = (c == 8'h00) || (c == 8'hff);
    endfunction

    function automatic logic inc_bit(input logic [1:0] f,
                                     input logic [1:0] l,
                                     input logic [2:0] p,
                                     input logic [7:0] c,
                                     input logic [1:0] pos);
        logic [2:0] k;
        logic [2:0] t;
        k = {c[1:0], c[7]};
        t = {p[0], l[0] ^ p[0], f[0] ^ l[0]};
        if (k == afd_pkg::AFD_LSB_TABLED) begin
            inc_bit = afd_pkg::AFD_PAT001[{f, l}][p][pos];
        end else begin
            inc_bit = (k > t);
        end
    endfunction

    function automatic logic [7:0] dith(input logic [7:0] c,
                                        input logic       inc);
        logic [5:0] top;
        top = c[7:2];
        if (inc && top != 6'h3f) begin
            top = top + 6'h01;
        end
        dith = {top, 2'h0};
    endfunction

    assign fs_a = pix_in.fs ~^ cfg.fs_pol;
    assign ls_a = pix_in.ls ~^ cfg.ls_pol;
    assign av_a = pix_in.av ~^ cfg.av_pol;
    assign step = ce & vld_in;
    assign l_start = cfg.de_only ? (av_a & ~av_d) : (ls_a & ~ls_d);
    assign f_start = cfg.de_only ? (av_a & ~av_d & ((gap_cnt >> 1) > run_len))
                                 : (fs_a & ~fs_d);
    assign frame_cur = f_start ? frame_idx + 2'h1 : frame_idx;
    assign line_cur  = f_start ? 2'h0 : (l_start ? line_idx + 2'h1 : line_idx);
    assign pix_cur   = l_start ? 3'h0 : pix_idx;

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            fs_d <= 1'b0;
            ls_d <= 1'b0;
            av_d <= 1'b0;
            gap_cnt <= 16'h0000;
            run_cnt <= 16'h0000;
            run_len <= 16'h0000;
        end else if (step) begin
            fs_d <= fs_a;
            ls_d <= ls_a;
            av_d <= av_a;
            gap_cnt <= av_a ? 16'h0000 : gap_cnt + {15'h0000, ~&gap_cnt};
            run_cnt <= av_a ? run_cnt + {15'h0000, ~&run_cnt} : 16'h0000;
            if (!av_a && av_d) begin
                run_len <= run_cnt;
            end
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            frame_idx <= 2'h0;
            line_idx <= 2'h0;
            pix_idx <= 3'h0;
        end else if (step) begin
            frame_idx <= frame_cur;
            line_idx <= line_cur;
            pix_idx <= av_a ? pix_cur + 3'h1 : pix_cur;
        end
    end

    always_comb begin
        if (pix_in.r == 8'h00 && pix_in.g == 8'h00 && pix_in.b == 8'h00) begin
            alg = afd_pkg::ALG_BLACK;
        end else if (&{pix_in.r, pix_in.g, pix_in.b}) begin
            alg = afd_pkg::ALG_WHITE;
        end else if (full(pix_in.r) || full(pix_in.g) || full(pix_in.b)) begin
            alg = afd_pkg::ALG_SUBPIX;
        end else begin
            alg = afd_pkg::ALG_DEFAULT;
        end
    end

    always_comb begin
        inc_r = inc_bit(frame_cur, line_cur, pix_cur, pix_in.r,
                        afd_pkg::AFD_CELL_R);
        inc_g = inc_bit(frame_cur, line_cur, pix_cur, pix_in.g,
                        afd_pkg::AFD_CELL_G);
        inc_b = inc_bit(frame_cur, line_cur, pix_cur, pix_in.b,
                        afd_pkg::AFD_CELL_B);
        unique case (alg)
            afd_pkg::ALG_BLACK, afd_pkg::ALG_WHITE: begin
                inc_r = 1'b0;
                inc_g = 1'b0;
                inc_b = 1'b0;
            end
            afd_pkg::ALG_SUBPIX: begin
                inc_r = inc_r & ~full(pix_in.r);
                inc_g = inc_g & ~full(pix_in.g);
                inc_b = inc_b & ~full(pix_in.b);
            end
            afd_pkg::ALG_DEFAULT: begin
            end
        endcase
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            vld_out <= 1'b0;
            pix_out <= '0;
        end else if (ce) begin
            vld_out <= vld_in;
            pix_out.fs <= pix_in.fs;
            pix_out.ls <= pix_in.ls;
            pix_out.av <= pix_in.av;
            if (cfg.en) begin
                pix_out.r <= dith(pix_in.r, inc_r);
                pix_out.g <= dith(pix_in.g, inc_g);
                pix_out.b <= dith(pix_in.b, inc_b);
            end else begin
                pix_out.r <= pix_in.r;
                pix_out.g <= pix_in.g;
                pix_out.b <= pix_in.b;
            end
        end
    end

    property p_low_zero;
        @(posedge pclk) disable iff (!presetn)
        $past(ce && cfg.en) |-> pix_out.r[1:0] == 2'h0 &&
            pix_out.g[1:0] == 2'h0 && pix_out.b[1:0] == 2'h0;
    endproperty
    a_low_zero: assert property (p_low_zero)
        else $error("Dithered lsbs not zero");

    property p_bypass;
        @(posedge pclk) disable iff (!presetn)
        ce && !cfg.en |=> pix_out == $past(pix_in);
    endproperty
    a_bypass: assert property (p_bypass)
        else $error("Disabled stage altered data");

    property p_black;
        @(posedge pclk) disable iff (!presetn)
        ce && cfg.en && pix_in.r == 8'h00 && pix_in.g == 8'h00 &&
            pix_in.b == 8'h00 |=> pix_out.r == 8'h00 &&
            pix_out.g == 8'h00 && pix_out.b == 8'h00;
    endproperty
    a_black: assert property (p_black)
        else $error("Black pixel dithered");

    property p_inc_one;
        @(posedge pclk) disable iff (!presetn)
        ce && cfg.en && pix_in.r == 8'h80 |=> pix_out.r inside {8'h80, 8'h84};
    endproperty
    a_inc_one: assert property (p_inc_one)
        else $error("Increment is not zero or one");

    property p_pix_wrap;
        @(posedge pclk) disable iff (!presetn)
        step && av_a && !l_start && pix_idx == 3'h7 |=> pix_idx == 3'h0;
    endproperty
    a_pix_wrap: assert property (p_pix_wrap)
        else $error("Pixel index did not wrap at eight");
endmodule

// ---- verilog/afd_top.sv ----
// Purpose: Two dither stages around a white balance table, APB control
// Assumes: Table answers in the same cycle it is addressed
// Notes:   Two-entry input buffer absorbs stalls from the panel side
//
// The APB register port and the register offsets are this design's own decisions.
`timescale 1ns/10ps
module afd_top (
    input  wire logic              pclk,
    input  wire logic              presetn,
    input  wire logic              psel,
    input  wire logic              penable,
    input  wire logic              pwrite,
    input  wire logic [11:0]       paddr,
    input  wire logic [31:0]       pwdata,
    output logic [31:0]            prdata,
    output logic                   pready,
    output logic                   pslverr,
    input  wire logic              in_valid,
    input  wire afd_pkg::afd_pix_s in_pix,
    output logic                   in_ready,
    output afd_pkg::afd_pix_s      table_pix,
    input  wire logic [23:0]       table_rdata,
    output logic                   out_valid,
    output afd_pkg::afd_pix_s      out_pix,
    input  wire logic              out_ready
);
    logic [6:0]          ctrl_reg;
    logic                access;
    logic                ce;
    logic                push;
    logic                pop;
    logic [1:0]          buf_cnt;
    logic [1:0]          buf_cnt_next;
    logic                wr_ptr;
    logic                rd_ptr;
    afd_pkg::afd_pix_s   buf_mem [2];
    logic                buf_valid;
    afd_pkg::afd_pix_s   buf_head;
    afd_pkg::afd_cfg_s   pre_cfg;
    afd_pkg::afd_cfg_s   post_cfg;
    logic                pre_vld;
    afd_pkg::afd_pix_s   post_in;
    logic [1:0]          pre_frame;
    logic [1:0]          post_frame;
    logic [31:0]         stat_val;

    function automatic logic hit(input logic [11:0] a,
                                 input logic [11:0] ofs);
        hit = (a == ofs);
    endfunction

    // APB access phase, first cycle only; pready follows one cycle later
    assign access = psel & penable & ~pready;

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            pready <= 1'b0;
        end else begin
            pready <= access;
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            pslverr <= 1'b0;
        end else begin
            pslverr <= access &
                       ~hit(paddr, afd_pkg::AFD_CTRL_OFS) &
                       ~hit(paddr, afd_pkg::AFD_STAT_OFS);
        end
    end

    assign stat_val = {24'h00_0000, buf_cnt, pre_frame, post_frame,
                       out_valid, in_ready};

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            prdata <= 32'h0000_0000;
        end else if (access && !pwrite) begin
            if (hit(paddr, afd_pkg::AFD_CTRL_OFS)) begin
                prdata <= {25'h000_0000, ctrl_reg};
            end else if (hit(paddr, afd_pkg::AFD_STAT_OFS)) begin
                prdata <= stat_val;
            end else begin
                prdata <= 32'h0000_0000;
            end
        end
    end

    // Write lands at the edge where pready is sampled high
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            ctrl_reg <= afd_pkg::AFD_CTRL_RST;
        end else if (psel && penable && pready && pwrite &&
                     hit(paddr, afd_pkg::AFD_CTRL_OFS)) begin
            ctrl_reg <= pwdata[6:0];
        end
    end

    // Both stages share the host timing description
    always_comb begin
        pre_cfg.en      = ctrl_reg[afd_pkg::AFD_PRE_EN];
        pre_cfg.de_only = ctrl_reg[afd_pkg::AFD_DE_ONLY];
        pre_cfg.fs_pol  = ctrl_reg[afd_pkg::AFD_FS_POL];
        pre_cfg.ls_pol  = ctrl_reg[afd_pkg::AFD_LS_POL];
        pre_cfg.av_pol  = ctrl_reg[afd_pkg::AFD_AV_POL];
        post_cfg        = pre_cfg;
        post_cfg.en     = ctrl_reg[afd_pkg::AFD_POST_EN];
    end

    // Pipeline moves whenever the output slot is free or being taken
    assign ce = ~out_valid | out_ready;

    assign buf_valid = (buf_cnt != 2'h0);
    assign buf_head  = buf_mem[rd_ptr];
    assign push      = in_valid & in_ready;
    assign pop       = ce & buf_valid;

    always_comb begin
        buf_cnt_next = buf_cnt;
        if (push && !pop) begin
            buf_cnt_next = buf_cnt + 2'h1;
        end else if (pop && !push) begin
            buf_cnt_next = buf_cnt - 2'h1;
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            buf_cnt <= 2'h0;
            in_ready <= 1'b1;
        end else begin
            buf_cnt <= buf_cnt_next;
            in_ready <= (buf_cnt_next != afd_pkg::AFD_BUF_DEPTH);
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            wr_ptr <= 1'b0;
            rd_ptr <= 1'b0;
        end else begin
            if (push) begin
                wr_ptr <= ~wr_ptr;
            end
            if (pop) begin
                rd_ptr <= ~rd_ptr;
            end
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            buf_mem[0] <= '0;
            buf_mem[1] <= '0;
        end else if (push) begin
            buf_mem[wr_ptr] <= in_pix;
        end
    end

    // First stage sits ahead of the table
    afd_dither u_pre_table_dither (
        .pclk      (pclk),
        .presetn   (presetn),
        .ce        (ce),
        .vld_in    (buf_valid),
        .cfg       (pre_cfg),
        .pix_in    (buf_head),
        .vld_out   (pre_vld),
        .pix_out   (table_pix),
        .frame_idx (pre_frame)
    );

    // Table output replaces colour, timing stays with the pixel
    always_comb begin
        post_in = table_pix;
        if (ctrl_reg[afd_pkg::AFD_WB_EN]) begin
            post_in.r = table_rdata[23:16];
            post_in.g = table_rdata[15:8];
            post_in.b = table_rdata[7:0];
        end
    end

    afd_dither u_post_table_dither (
        .pclk      (pclk),
        .presetn   (presetn),
        .ce        (ce),
        .vld_in    (pre_vld),
        .cfg       (post_cfg),
        .pix_in    (post_in),
        .vld_out   (out_valid),
        .pix_out   (out_pix),
        .frame_idx (post_frame)
    );

    sequence s_setup;
        psel && !penable;
    endsequence

    sequence s_access;
        psel && penable && !pready;
    endsequence

    property p_apb_answer;
        @(posedge pclk) disable iff (!presetn)
        s_setup ##1 s_access |=> pready ##1 !pready;
    endproperty
    a_apb_answer: assert property (p_apb_answer)
        else $error("APB answer not one wait state");

    property p_ctrl_write;
        @(posedge pclk) disable iff (!presetn)
        psel && penable && pready && pwrite &&
            paddr == afd_pkg::AFD_CTRL_OFS
            |=> ctrl_reg == $past(pwdata[6:0]);
    endproperty
    a_ctrl_write: assert property (p_ctrl_write)
        else $error("Control write not applied");

    property p_ready_full;
        @(posedge pclk) disable iff (!presetn)
        buf_cnt == afd_pkg::AFD_BUF_DEPTH |-> !in_ready;
    endproperty
    a_ready_full: assert property (p_ready_full)
        else $error("Ready high with buffer full");

    property p_out_hold;
        @(posedge pclk) disable iff (!presetn)
        out_valid && !out_ready |=> out_valid && $stable(out_pix);
    endproperty
    a_out_hold: assert property (p_out_hold)
        else $error("Output changed while stalled");

    property p_pre_feed;
        @(posedge pclk) disable iff (!presetn)
        ce && pre_cfg.en && buf_valid |=> table_pix.r[1:0] == 2'h0 &&
            table_pix.g[1:0] == 2'h0;
    endproperty
    a_pre_feed: assert property (p_pre_feed)
        else $error("Table input not reduced");

    property p_post_src;
        @(posedge pclk) disable iff (!presetn)
        ce && pre_vld && !post_cfg.en && ctrl_reg[afd_pkg::AFD_WB_EN]
            |=> out_pix.r == $past(table_rdata[23:16]) &&
            out_pix.b == $past(table_rdata[7:0]);
    endproperty
    a_post_src: assert property (p_post_src)
        else $error("Second stage not fed from table");

    property p_latency;
        @(posedge pclk) disable iff (!presetn)
        ce && buf_valid ##1 ce |=> out_valid;
    endproperty
    a_latency: assert property (p_latency)
        else $error("Pipeline latency not two cycles");
endmodule
